// ---- pid_defs.svh ----
// constants of the closed-loop process regulator
`ifndef PID_DEFS_SVH
`define PID_DEFS_SVH
// special function code that enables the regulator
`define SPECIAL_FN_REGULATOR   4'h1
// digital input function code for manual/automatic selection
`define MANUAL_AUTO_FN_CODE    5'h1B
// valid reference source codes while the regulator runs
`define REF_SRC_KEYPAD         3'h0
`define REF_SRC_POT            3'h3
// programming fault code shown on an invalid reference source
`define PROGRAMMING_FAULT_CODE 8'h18
// action type and setpoint copy codes
`define ACTION_DIRECT          1'h0
`define COPY_ENABLED           1'h0
// percentages carry one decimal: 1000 = 100.0 %
`define PCT_FULL               16'h03E8
// 4 mA live zero of a 4-20 mA loop is 20 % of full scale
`define LIVE_ZERO              16'h00C8
// gains carry one decimal: 1000 = 100.0 %
`define GAIN_UNITY             16'h03E8
// control update period in ns and its count of 25 ns cycles
`define UPDATE_PERIOD_NS       1000
`define CLK_PERIOD_NS          25
`define UPDATE_CYCLES          (`UPDATE_PERIOD_NS / `CLK_PERIOD_NS)
// reset values
`define SETPOINT_RESET         16'h0000
`endif

// ---- pid_pkg.sv ----
// types shared by the regulator files
`default_nettype none
package pid_pkg;
  // feedback transducer signal types
  typedef enum logic [1:0] {
    sig_4_20ma  = 2'b00,
    sig_0_20ma  = 2'b01,
    sig_0_10v   = 2'b10
  } signal_type;
  // regulator operating mode
  typedef enum logic [0:0] {
    mode_manual = 1'b0,
    mode_auto   = 1'b1
  } mode_type;
endpackage
`default_nettype wire

// ---- feedback_conditioner.sv ----
// conditions analog input one into a feedback percentage
`default_nettype none
`include "pid_defs.svh"
module feedback_conditioner
  import pid_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] analog_input_one,  // raw reading, 1000 = sensor full scale
  input  wire logic [1:0]  feedback_signal_type,
  input  wire logic [15:0] feedback_gain,     // 1000 = 100.0 %
  input  wire logic [15:0] feedback_offset,   // signed, 0.1 % units
  output logic [15:0]      feedback_pct       // 0.1 % units, clamped 0..100 %
);
  // =====================================================
  // state
  typedef struct packed {
    logic [15:0] pct;
  } state_type;
  state_type s_q, s_d;
  logic [31:0] span;     // input mapped over its live range
  logic [31:0] scaled;   // span after gain
  logic signed [33:0] biased; // after offset

  // =====================================================
  // combinational conditioning
  always_comb begin
    s_d = s_q;
    span = 32'h0;
    unique case (signal_type'(feedback_signal_type))
      sig_4_20ma: begin
        // live zero removed, then stretched back to full scale
        if (analog_input_one > `LIVE_ZERO)
          span = ((32'(analog_input_one) - 32'(`LIVE_ZERO)) * 32'(`PCT_FULL))
                 / (32'(`PCT_FULL) - 32'(`LIVE_ZERO)); // RQ15
      end
      default: span = 32'(analog_input_one); // RQ15
    endcase
    scaled = (span * 32'(feedback_gain)) / 32'(`GAIN_UNITY); // RQ16
    biased = $signed({2'b00, scaled}) + 34'($signed(feedback_offset)); // RQ16
    // clamp keeps the percentage inside 0..100 %
    if (biased < 0)
      s_d.pct = 16'h0000;
    else if (biased > $signed({18'h0, `PCT_FULL}))
      s_d.pct = `PCT_FULL;
    else
      s_d.pct = biased[15:0];
  end

  // =====================================================
  // register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign feedback_pct = s_q.pct;
endmodule
`default_nettype wire

// ---- pid_core.sv ----
// proportional, integral and differential action on one error
`default_nettype none
`include "pid_defs.svh"
module pid_core (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               tick,          // one update period elapsed
  input  wire logic               run,           // automatic mode active
  input  wire logic signed [17:0] error,         // 0.1 % units
  input  wire logic [15:0]        proportional_gain,
  input  wire logic [15:0]        integral_gain,
  input  wire logic [15:0]        differential_gain,
  input  wire logic [15:0]        preset,        // output loaded while idle
  output logic [15:0]             out_pct        // 0.1 % units, 0..100 %
);
  // =====================================================
  // state
  typedef struct packed {
    logic signed [31:0] integ;   // integral accumulator
    logic signed [17:0] last;    // previous error
    logic [15:0]        out;
  } state_type;
  state_type s_q, s_d;
  logic signed [31:0] p_term;
  logic signed [31:0] i_step;
  logic signed [31:0] d_term;
  logic signed [31:0] sum;

  // saturate to the 0..100 % band
  function automatic logic signed [31:0] sat(input logic signed [31:0] v);
    if (v < 0)
      sat = 32'sh0;
    else if (v > $signed({16'h0, `PCT_FULL}))
      sat = $signed({16'h0, `PCT_FULL});
    else
      sat = v;
  endfunction

  // =====================================================
  // update
  always_comb begin
    s_d = s_q;
    // each term carries its own gain
    p_term = (32'(error) * $signed({16'h0, proportional_gain})) / 32'sh3E8; // RQ14
    i_step = (32'(error) * $signed({16'h0, integral_gain})) / 32'sh2710;   // RQ14
    d_term = (32'(error - s_q.last) * $signed({16'h0, differential_gain})) / 32'sh3E8; // RQ14
    sum = 32'sh0;
    if (!run) begin
      // bumpless: hold the integrator at the current output
      s_d.integ = $signed({16'h0, preset});
      s_d.last  = error;
      s_d.out   = preset;
    end else if (tick) begin
      // clamped integrator avoids windup at the limits
      s_d.integ = sat(s_q.integ + i_step);
      s_d.last  = error;
      sum       = sat(s_d.integ + p_term + d_term);
      s_d.out   = sum[15:0];
    end
  end

  // =====================================================
  // register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign out_pct = s_q.out;
endmodule
`default_nettype wire

// ---- process_regulator.sv ----
// closed-loop process regulator of the drive, top level
//
// Behaviour
// RQ1: feedback comes only from analog input one
// RQ2: setpoint percentage from keypad or potentiometer
// RQ3: process variable display shows scaled feedback
// RQ4: display equals feedback percent times scale
// RQ5: regulator active only when special function is 1
// RQ6: code 27 input: closed manual, open automatic
// RQ7: no code 27 input means always automatic
// RQ8: invalid reference source raises programming fault
// RQ9: operator sets reference sources only 0 or 3
// RQ10: manual mode uses open-loop frequency reference
// RQ11: copy enabled: load setpoint from PV on auto
// RQ12: copy disabled: setpoint unchanged on auto
// RQ13: direct raises speed, reverse lowers speed
// RQ14: output sums separately weighted P, I, D
// RQ15: feedback conditioned by selected signal type
// RQ16: feedback scaled by gain and offset
// RQ17: speed output clamped between speed limits; in manual or when disabled open_loop_reference passes unclamped
// RQ18: error is setpoint minus feedback, per period
`default_nettype none
`include "pid_defs.svh"
module process_regulator
  import pid_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] analog_input_one,           // feedback reading, 1000 = full scale
  input  wire logic [15:0] potentiometer_input,        // panel pot, 0.1 % units
  input  wire logic [3:0]  special_function_select,
  input  wire logic [2:0]  local_reference_source,
  input  wire logic [2:0]  remote_reference_source,
  input  wire logic        remote_select,              // high selects the remote source
  input  wire logic [3:0]  manual_auto_selector_input, // levels of the four digital inputs
  input  wire logic [19:0] input_function_codes,       // 5 bits per input, first to last
  input  wire logic        setpoint_write,             // keypad store strobe
  input  wire logic [15:0] setpoint_write_data,        // 0.1 % units
  input  wire logic        setpoint_copy_disable,
  input  wire logic        control_action_type,
  input  wire logic [15:0] proportional_gain,
  input  wire logic [15:0] integral_gain,
  input  wire logic [15:0] differential_gain,
  input  wire logic [1:0]  feedback_signal_type,
  input  wire logic [15:0] feedback_gain,
  input  wire logic [15:0] feedback_offset,
  input  wire logic [15:0] pv_scale_factor,            // 0.1 units
  input  wire logic [15:0] minimum_speed_limit,        // frequency units
  input  wire logic [15:0] maximum_speed_limit,
  input  wire logic [15:0] open_loop_reference,        // ordinary frequency reference
  output logic [15:0]      digital_setpoint_param,     // stored keypad setpoint
  output logic [31:0]      process_variable_display,   // 0.01 process units
  output logic [15:0]      frequency_reference,
  output logic             automatic_mode,
  output logic             programming_fault,
  output logic [7:0]       programming_fault_code
);
  // =====================================================
  // state
  typedef struct packed {
    logic [15:0] setpoint;   // keypad setpoint
    logic [31:0] pv;         // displayed process variable
    logic [15:0] freq;       // applied frequency reference
    mode_type    mode;       // mode seen last cycle
    logic        fault;
    logic [5:0]  timer;      // update period counter
  } state_type;
  state_type s_q, s_d;

  logic [15:0]        fb_pct;     // conditioned feedback
  logic [15:0]        pid_out;    // regulator output, 0.1 %
  logic               tick;       // update period strobe
  logic               enabled;    // regulator function selected
  logic               have_sel;   // some input carries the mode code
  logic               manual_req; // a selector input is closed
  mode_type           mode_now;
  logic [2:0]         active_src;
  logic [15:0]        sp_pct;     // setpoint in use
  logic signed [17:0] err;
  logic signed [17:0] err_dir;
  logic [31:0]        span_f;
  logic [31:0]        speed;
  logic [15:0]        closed_ref;

  // reference source code that the regulator cannot work with
  function automatic logic bad_source(input logic [2:0] src);
    bad_source = (src != `REF_SRC_KEYPAD) && (src != `REF_SRC_POT);
  endfunction

  // =====================================================
  // feedback path, only analog input one feeds it
  feedback_conditioner u_fb (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .analog_input_one     (analog_input_one),      // RQ1
    .feedback_signal_type (feedback_signal_type),
    .feedback_gain        (feedback_gain),
    .feedback_offset      (feedback_offset),
    .feedback_pct         (fb_pct)
  );

  // =====================================================
  // regulator core
  pid_core u_core (
    .sys_clk           (sys_clk),
    .rst               (rst),
    .tick              (tick),
    .run               (enabled && (mode_now == mode_auto)),
    .error             (err_dir),
    .proportional_gain (proportional_gain),
    .integral_gain     (integral_gain),
    .differential_gain (differential_gain),
    .preset            (closed_ref_pct(s_q.freq)),
    .out_pct           (pid_out)
  );

  // frequency back to percent of the maximum limit, for a bumpless start
  function automatic logic [15:0] closed_ref_pct(input logic [15:0] f);
    logic [31:0] t;
    t = 32'h0;
    if (maximum_speed_limit != 16'h0000)
      t = (32'(f) * 32'(`PCT_FULL)) / 32'(maximum_speed_limit);
    closed_ref_pct = (t > 32'(`PCT_FULL)) ? `PCT_FULL : t[15:0];
  endfunction

  // =====================================================
  // mode selection from the digital inputs
  always_comb begin
    have_sel   = 1'b0;
    manual_req = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (input_function_codes[i*5 +: 5] == `MANUAL_AUTO_FN_CODE) begin
        have_sel = 1'b1;                                          // RQ6
        if (manual_auto_selector_input[i])
          manual_req = 1'b1;                                      // RQ6
      end
    end
    // with no selector programmed the loop stays closed
    mode_now = (have_sel && manual_req) ? mode_manual : mode_auto; // RQ7
  end

  assign enabled    = (special_function_select == `SPECIAL_FN_REGULATOR); // RQ5
  assign active_src = remote_select ? remote_reference_source : local_reference_source;
  assign tick       = (s_q.timer == 6'(`UPDATE_CYCLES - 1));

  // =====================================================
  // setpoint, error and speed conversion
  always_comb begin
    // pot only when that source is chosen, else keypad value
    sp_pct = (active_src == `REF_SRC_POT) ? potentiometer_input : s_q.setpoint; // RQ2
    err = $signed({2'b00, sp_pct}) - $signed({2'b00, fb_pct}); // RQ18
    // reverse action flips the sign so speed rises as the PV rises
    err_dir = (control_action_type == `ACTION_DIRECT) ? err : -err; // RQ13
    // percent of maximum limit, then clamped to the limits
    span_f = (32'(pid_out) * 32'(maximum_speed_limit)) / 32'(`PCT_FULL);
    if (span_f < 32'(minimum_speed_limit))
      speed = 32'(minimum_speed_limit);                       // RQ17
    else if (span_f > 32'(maximum_speed_limit))
      speed = 32'(maximum_speed_limit);                       // RQ17
    else
      speed = span_f;
    closed_ref = speed[15:0];
  end

  // =====================================================
  // next state
  always_comb begin
    s_d = s_q;
    // update period counter
    s_d.timer = tick ? 6'h00 : s_q.timer + 6'h01;
    // display tracks the feedback: percent times scale factor
    s_d.pv = 32'(fb_pct) * 32'(pv_scale_factor);               // RQ3 RQ4
    s_d.mode = mode_now;
    s_d.fault = enabled && (bad_source(local_reference_source)
                || bad_source(remote_reference_source));       // RQ8
    // keypad store
    if (setpoint_write)
      s_d.setpoint = (setpoint_write_data > `PCT_FULL) ? `PCT_FULL : setpoint_write_data;
    // manual to automatic: copy the feedback percentage at the change into the setpoint
    if (enabled && (s_q.mode == mode_manual) && (mode_now == mode_auto)) begin
      if (setpoint_copy_disable == `COPY_ENABLED)
        s_d.setpoint = fb_pct;                                 // RQ11
      // otherwise the stored setpoint stays as it was       // RQ12
    end
    // reference: open loop in manual or when disabled
    if (!enabled || mode_now == mode_manual)
      s_d.freq = open_loop_reference;                          // RQ10
    else
      s_d.freq = closed_ref;                                   // RQ14 RQ17
  end

  // =====================================================
  // register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.setpoint <= `SETPOINT_RESET;
      s_q.mode     <= mode_auto;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================
  // outputs
  assign digital_setpoint_param   = s_q.setpoint;
  assign process_variable_display = s_q.pv;
  assign frequency_reference      = s_q.freq;
  assign automatic_mode           = (s_q.mode == mode_auto);
  assign programming_fault        = s_q.fault;
  assign programming_fault_code   = s_q.fault ? `PROGRAMMING_FAULT_CODE : 8'h00;
endmodule
`default_nettype wire

// ---- process_regulator_sva.sv ----
// checker for the closed-loop process regulator top level
`default_nettype none
`include "pid_defs.svh"
module process_regulator_sva (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [3:0]  special_function_select,
  input wire logic [2:0]  local_reference_source,
  input wire logic [2:0]  remote_reference_source,
  input wire logic [3:0]  manual_auto_selector_input,
  input wire logic [19:0] input_function_codes,
  input wire logic        setpoint_write,
  input wire logic [15:0] setpoint_write_data,
  input wire logic        setpoint_copy_disable,
  input wire logic [15:0] minimum_speed_limit,
  input wire logic [15:0] maximum_speed_limit,
  input wire logic [15:0] open_loop_reference,
  input wire logic [15:0] digital_setpoint_param,
  input wire logic [15:0] frequency_reference,
  input wire logic        automatic_mode,
  input wire logic        programming_fault,
  input wire logic [7:0]  programming_fault_code
);
  // ==========================================
  // helper logic
  logic [1:0] age_q;    // edges since reset, saturating
  logic [3:0] sel_hit;  // inputs carrying the mode-select code
  logic       reg_on;   // regulator enabled
  logic       bad;      // an invalid reference source is set
  logic       man_exp;  // manual mode expected
  logic       olr_in;   // open-loop reference inside the limits
  // wait out reset so past samples are meaningful
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  // expected mode and fault from the settings
  always_comb begin
    for (int i = 0; i < 4; i++) sel_hit[i] = input_function_codes[5*i +: 5] == `MANUAL_AUTO_FN_CODE;
    reg_on  = special_function_select == `SPECIAL_FN_REGULATOR;
    bad     = reg_on && !(local_reference_source inside {3'h0, 3'h3} &&
                          remote_reference_source inside {3'h0, 3'h3});
    man_exp = reg_on && |(sel_hit & manual_auto_selector_input);
    olr_in  = open_loop_reference >= minimum_speed_limit && open_loop_reference <= maximum_speed_limit;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // properties
  property p_fault_code;
    programming_fault_code == (programming_fault ? `PROGRAMMING_FAULT_CODE : 8'h00);
  endproperty
  a_fault_code: assert property (p_fault_code) else $error("fault code does not follow fault");
  property p_fault_on;
    age_q == 2'h3 && bad && $past(bad) && $past(bad, 2) |-> programming_fault;
  endproperty
  a_fault_on: assert property (p_fault_on) else $error("fault missing on bad source");
  property p_fault_off;
    age_q == 2'h3 && !bad && !$past(bad) && !$past(bad, 2) |-> !programming_fault;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault without cause");
  property p_mode;
    age_q == 2'h3 && reg_on && $past(reg_on) && man_exp == $past(man_exp) && $past(man_exp) == $past(man_exp, 2)
      |-> automatic_mode == !man_exp;
  endproperty
  a_mode: assert property (p_mode) else $error("mode does not follow selector");
  property p_manual_freq;
    age_q == 2'h3 && !automatic_mode && !$past(automatic_mode) && $stable(open_loop_reference) && olr_in
      |-> frequency_reference == open_loop_reference;
  endproperty
  a_manual_freq: assert property (p_manual_freq) else $error("manual reference not passed");
  property p_copy_off;
    $rose(automatic_mode) && $past(setpoint_copy_disable) && !$past(setpoint_write) |-> $stable(digital_setpoint_param);
  endproperty
  a_copy_off: assert property (p_copy_off) else $error("setpoint changed with copy off");
  property p_write;
    setpoint_write |=> $rose(automatic_mode) || digital_setpoint_param ==
      ($past(setpoint_write_data) > `PCT_FULL ? `PCT_FULL : $past(setpoint_write_data));
  endproperty
  a_write: assert property (p_write) else $error("setpoint store wrong");
  property p_speed_lim;
    age_q == 2'h3 && automatic_mode && $past(automatic_mode) && reg_on && $past(reg_on) &&
      $stable(minimum_speed_limit) && $stable(maximum_speed_limit) && minimum_speed_limit <= maximum_speed_limit
      |-> frequency_reference >= minimum_speed_limit && frequency_reference <= maximum_speed_limit;
  endproperty
  a_speed_lim: assert property (p_speed_lim) else $error("speed outside limits");
  // main scenarios reached
  c_fault: cover property ($rose(programming_fault));
  c_auto:  cover property ($rose(automatic_mode) && !$past(setpoint_copy_disable));
  c_man:   cover property ($fell(automatic_mode));
endmodule
bind process_regulator process_regulator_sva u_sva (.*);
`default_nettype wire

// ---- process_transducer.sv ----
// feedback transducer model driving analog input one
`default_nettype none
`include "pid_defs.svh"
module process_transducer (
  input  wire logic [15:0] level_pct,   // process level, 0.1 % units
  input  wire logic [1:0]  signal_type, // loop kind of the transducer
  output logic [15:0]      reading      // raw reading, 1000 = full scale
);
  timeunit 1ns;
  timeprecision 100ps;
  // a live-zero loop never reads below its offset, so 0 % is 200
  assign reading = (signal_type == 2'b00) ? 16'(32'(`LIVE_ZERO) + 32'(level_pct) * 32'h320 / 32'h3E8) : level_pct;
endmodule
`default_nettype wire

// ---- process_regulator_tb_top.sv ----
// self-checking testbench of the process regulator
`default_nettype none
module process_regulator_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pid_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] analog_input_one, potentiometer_input, setpoint_write_data, proportional_gain, integral_gain;
  logic [15:0] differential_gain, feedback_gain, feedback_offset, pv_scale_factor, minimum_speed_limit;
  logic [15:0] maximum_speed_limit, open_loop_reference, digital_setpoint_param, frequency_reference, level_pct;
  logic [3:0]  special_function_select, manual_auto_selector_input;
  logic [2:0]  local_reference_source, remote_reference_source;
  logic [19:0] input_function_codes;
  logic [1:0]  feedback_signal_type;
  logic        remote_select, setpoint_write, setpoint_copy_disable, control_action_type;
  logic        automatic_mode, programming_fault;
  logic [31:0] process_variable_display;
  logic [7:0]  programming_fault_code;
  int          mismatches = 0;
  int          compares = 0;
  always #12.5 sys_clk = ~sys_clk;
  process_regulator u_dut (.*);
  process_transducer u_src (.level_pct(level_pct), .signal_type(feedback_signal_type), .reading(analog_input_one));
  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // inputs always move 2 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic wr(input logic [15:0] v);
    setpoint_write = 1'b1;
    setpoint_write_data = v;
    cyc(1);
    setpoint_write = 1'b0;
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_fault;
    special_function_select = 4'h1;
    for (int i = 0; i < 16; i++) begin
      local_reference_source = i[3] ? i[2:0] : 3'h0;
      remote_reference_source = i[3] ? 3'h0 : i[2:0];
      remote_select = i[0];
      cyc(3);
      chk("fault", programming_fault, !(i[2:0] inside {0, 3}));
      chk("fault_code", programming_fault_code, (i[2:0] inside {0, 3}) ? 8'h00 : 8'h18);
    end
    special_function_select = 4'h0;
    cyc(3);
    chk("fault_off", programming_fault, 1'b0);
    local_reference_source = 3'h0;
    special_function_select = 4'h1;
    $display("t_fault done");
  endtask
  task automatic t_display;
    level_pct = 16'h01F4;
    cyc(4);
    chk("pv_0_20", process_variable_display, 32'h30D4);
    potentiometer_input = 16'h0300;
    cyc(4);
    chk("pv_pot", process_variable_display, 32'h30D4);
    for (int t = 0; t < 3; t = t + 2) begin
      feedback_signal_type = 2'(t);
      cyc(4);
      chk("pv_type", process_variable_display, 32'h30D4);
    end
    feedback_signal_type = 2'b01;
    feedback_gain = 16'h07D0;
    level_pct = 16'h012C;
    cyc(4);
    chk("pv_gain", process_variable_display, 32'h3A98);
    // +10.0 % offset on top of the doubled reading
    feedback_offset = 16'h0064;
    cyc(4);
    chk("pv_offset", process_variable_display, 32'h445C);
    feedback_offset = 16'h0000;
    feedback_gain = 16'h03E8;
    level_pct = 16'h01F4;
    $display("t_display done");
  endtask
  task automatic t_mode;
    input_function_codes = {5'h00, 5'h1B, 5'h00, 5'h00};
    manual_auto_selector_input = 4'h4;
    cyc(3);
    chk("manual", automatic_mode, 1'b0);
    chk("open_loop", frequency_reference, 16'h012C);
    manual_auto_selector_input = 4'h2;
    cyc(3);
    chk("auto_other", automatic_mode, 1'b1);
    input_function_codes = 20'h00000;
    manual_auto_selector_input = 4'hF;
    cyc(3);
    chk("auto_none", automatic_mode, 1'b1);
    $display("t_mode done");
  endtask
  task automatic t_copy;
    input_function_codes = {5'h00, 5'h1B, 5'h00, 5'h00};
    manual_auto_selector_input = 4'h4;
    cyc(3);
    wr(16'h0064);
    cyc(2);
    chk("sp_write", digital_setpoint_param, 16'h0064);
    manual_auto_selector_input = 4'h0;
    cyc(3);
    chk("sp_copy", digital_setpoint_param, 16'h01F4);
    manual_auto_selector_input = 4'h4;
    setpoint_copy_disable = 1'b1;
    cyc(3);
    wr(16'h07D0);
    cyc(2);
    chk("sp_clamp", digital_setpoint_param, 16'h03E8);
    manual_auto_selector_input = 4'h0;
    cyc(3);
    chk("sp_keep", digital_setpoint_param, 16'h03E8);
    $display("t_copy done");
  endtask
  // full error drives the output to one limit or the other
  task automatic t_action;
    level_pct = 16'h0000;
    integral_gain = 16'h03E8;
    cyc(800);
    chk("direct", frequency_reference, 16'h0258);
    control_action_type = 1'b1;
    cyc(800);
    chk("reverse", frequency_reference, 16'h0064);
    // pot setpoint 0 below a 50 % feedback: keypad value would push speed up instead
    control_action_type = 1'b0;
    {remote_reference_source, potentiometer_input, level_pct} = {3'h3, 16'h0000, 16'h01F4};
    cyc(800);
    chk("pot_sp", frequency_reference, 16'h0064);
    $display("t_action done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    {potentiometer_input, setpoint_write_data, integral_gain, differential_gain, feedback_offset} = '0;
    {proportional_gain, feedback_gain, level_pct} = {16'h03E8, 16'h03E8, 16'h0000};
    {pv_scale_factor, minimum_speed_limit, maximum_speed_limit} = {16'h0019, 16'h0064, 16'h0258};
    {open_loop_reference, special_function_select, manual_auto_selector_input} = {16'h012C, 8'h10};
    {local_reference_source, remote_reference_source, input_function_codes} = '0;
    {feedback_signal_type, remote_select, setpoint_write} = 4'h4;
    {setpoint_copy_disable, control_action_type} = 2'b00;
    // rst starts high with no edge on it, so the registers only clear at the first clock
    cyc(1);
    chk("rst_auto", automatic_mode, 1'b1);
    chk("rst_freq", frequency_reference, 16'h0000);
    cyc(9);
    rst = 1'b0;
    cyc(1);
    t_fault();
    t_display();
    t_mode();
    t_copy();
    t_action();
    final_report();
  end
  // hang guard
  initial begin
    #1ms;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
